// [common/sgr_pkg.sv]
package sgr_pkg;
  // Bus and scaling
  localparam int unsigned DATA_W     = 32;
  localparam int unsigned ADDR_W     = 8;
  localparam int unsigned FLOW_W     = 11;
  localparam int unsigned GAIN_W     = 11;
  localparam int unsigned SPEED_W    = 12;
  localparam int unsigned FRAC_W     = 8;
  localparam int unsigned NUM_GAINS  = 6;
  localparam int          MAX_FLOW   = 1000;
  localparam int          GAIN_UNITY = 100;
  localparam int          SHAPE_DIV  = 10000;

  // Tick timing
  localparam int          CLK_HZ      = 50_000_000;
  localparam int          TICK_MS     = 1;
  localparam int          TICK_CYCLES = CLK_HZ / 1000 * TICK_MS;

  // Register byte offsets
  localparam logic [ADDR_W-1:0] OFS_CTRL       = 8'h00;
  localparam logic [ADDR_W-1:0] OFS_SPEED_LIM  = 8'h04;
  localparam logic [ADDR_W-1:0] OFS_GAIN0      = 8'h08;
  localparam logic [ADDR_W-1:0] OFS_GAIN_LAST  = 8'h1C;
  localparam logic [ADDR_W-1:0] OFS_RISE_TIME  = 8'h20;
  localparam logic [ADDR_W-1:0] OFS_FALL_SLOW  = 8'h24;
  localparam logic [ADDR_W-1:0] OFS_FALL_FAST  = 8'h28;
  localparam logic [ADDR_W-1:0] OFS_FAST_THR   = 8'h2C;
  localparam logic [ADDR_W-1:0] OFS_ABORT_THR  = 8'h30;
  localparam logic [ADDR_W-1:0] OFS_ABORT_TIME = 8'h34;
  localparam logic [ADDR_W-1:0] OFS_STATUS     = 8'h38;

  // Control and status register fields
  localparam int CTRL_SENS_LSB  = 0;
  localparam int CTRL_RAMP_LSB  = 4;
  localparam int CTRL_RISE_LSB  = 8;
  localparam int CTRL_FALL_LSB  = 12;
  localparam int STAT_FLOW_LSB  = 16;

  // Selector encodings
  localparam logic [1:0] SENS_FIXED    = 2'h1;
  localparam logic [1:0] SENS_ACTUATOR = 2'h2;
  localparam logic [1:0] SENS_SPEED    = 2'h3;

  typedef enum logic [1:0] {
    SGR_RAMP_OFF   = 2'h0,
    SGR_RAMP_FIXED = 2'h1,
    SGR_RAMP_SPEED = 2'h2
  } sgr_ramp_t;

  // Legal ranges and reset values
  localparam int SPEED_LIM_MIN = 1;
  localparam int SPEED_LIM_MAX = 1000;
  localparam int SPEED_LIM_RST = 500;
  localparam int GAIN_MIN      = 20;
  localparam int GAIN_MAX      = 1200;
  localparam int GAIN_RST0     = 105;
  localparam int GAIN_RST_STEP = 15;
  localparam int TIME_MIN      = 1;
  localparam int TIME_MAX      = 1000;
  localparam int RISE_RST      = 1;
  localparam int FALL_SLOW_RST = 350;
  localparam int FALL_FAST_RST = 100;
  localparam int ABORT_TIME_RST = 175;
  localparam int FAST_THR_RST  = 1000;
  localparam int ABORT_THR_MAX = 500;
  localparam int ABORT_OFF     = 1000;
  localparam int SHAPE_MAX     = 10;

  // Breakpoint shifts: 1/16, 1/8, 1/4, 1/2, 1/1 of the limit
  localparam int BP_SHIFT0 = 4;

  // Ramp configuration carrier
  typedef struct packed {
    sgr_ramp_t   method;
    logic [3:0]  rise_curve_shape;
    logic [3:0]  fall_curve_shape;
    logic [9:0]  rise_time;
    logic [9:0]  fall_slow_time;
    logic [9:0]  fall_fast_time;
    logic [9:0]  fast_fall_threshold;
    logic [9:0]  fall_abort_threshold;
    logic [9:0]  abort_time;
  } sgr_ramp_cfg_t;
endpackage

// [rtl/sgr_top.sv]
`timescale 1ns/1ps
// What this block does
// RL1 - Selector value 3 takes the gain from vehicle speed
// RL2 - Gain between adjacent breakpoints is linearly interpolated
// RL3 - Negative speeds use the speed magnitude for the gain
// RL4 - Zero speed gives the standstill gain; unmapped speed keeps the standstill gain
// RL5 - Breakpoints sit at 6.25, 12.5, 25, 50, 100 percent of limit
// RL6 - Speed limit accepts 1 to 1000, default 500
// RL7 - Gains accept 20 to 1200, defaults 105 down to 30
// RL8 - Software keeps gains non-increasing with rising speed
// RL9 - Ramp method 0 off by default, 1 fixed, 2 speed dependent; code runs 2 on the fixed times like 1
// RL10 - Ramping acts on the spool set-point, rate-limiting the request
// RL11 - Rise time is zero to full flow, both ports
// RL12 - Slow fall time is full flow to zero, both ports
// RL13 - Separate shape settings bend rise and slow fall; default linear
// RL14 - Above the fast threshold fall fast, below it fall slow
// RL15 - Fast threshold 1000 removes the fast fall region
// RL16 - Fast fall time is a full-scale time, scaled by range width
// RL17 - Software keeps fast fall time below slow fall time
// RL18 - Opposite request past abort threshold aborts a slow fall
// RL19 - After an abort the fall uses the abort time
// RL20 - Abort threshold 1000 disables the abort
// RL21 - Software sets abort time well below slow fall time
// RL22 - Abort threshold accepts 0 to 500, unit 0.1 percent
// RL23 - Rise and slow fall times accept 1 to 1000 ms, defaults 1 and 350
// RL24 - At or above the speed limit the highest-speed gain holds
// RL25 - Set-point steps toward the request once per 1 ms tick
module sgr_top
  import sgr_pkg::*;
#(
  parameter int TICK_DIV = TICK_CYCLES
) (
  // Clock and reset
  input  wire logic                     pclk,
  input  wire logic                     presetn,
  // APB slave
  input  wire logic                     psel,
  input  wire logic                     penable,
  input  wire logic                     pwrite,
  input  wire logic [ADDR_W-1:0]        paddr,
  input  wire logic [DATA_W-1:0]        pwdata,
  output logic      [DATA_W-1:0]        prdata,
  output logic                          pready,
  output logic                          pslverr,
  // Steering and vehicle inputs
  input  wire logic signed [FLOW_W-1:0] steer_input,
  input  wire logic signed [SPEED_W:0]  vehicle_speed_value,
  // Spool side
  output logic signed [FLOW_W-1:0]      spool_setpoint,
  output logic signed [FLOW_W-1:0]      requested_flow,
  output logic        [GAIN_W-1:0]      active_gain
);

  // Configuration state
  logic [1:0]          sens_sel;
  logic [9:0]          speed_limit;
  logic [GAIN_W-1:0]   gain_tab [NUM_GAINS];
  sgr_ramp_cfg_t       cfg;

  // Tick divider, ramp and bus state
  logic [31:0]         tick_cnt;
  logic                tick;
  logic [FLOW_W+FRAC_W-1:0] sp_mag;
  logic                sp_neg;
  logic                aborted;
  logic                acc;
  logic                wr_en;
  logic                hit;

  // Combinational results
  logic [GAIN_W-1:0]   next_gain;
  logic signed [FLOW_W-1:0] next_flow;
  logic [FLOW_W+FRAC_W-1:0] next_sp_mag;
  logic                next_sp_neg;
  logic                next_aborted;
  logic [DATA_W-1:0]   rd_val;

  // Clamp a written value into its legal range
  function automatic logic [GAIN_W-1:0] clip(input logic [DATA_W-1:0] v,
                                             input int lo, input int hi);
    int x;
    x = int'(v[15:0]);
    if (x < lo) x = lo;
    if (x > hi) x = hi;
    return GAIN_W'(x);
  endfunction

  assign acc   = psel && penable;
  assign wr_en = acc && pready && pwrite;

  // Address decode; gain slots form one aligned word each
  always_comb begin
    hit    = 1'b1;
    rd_val = '0;
    unique case (paddr)
      OFS_CTRL: begin
        rd_val[CTRL_SENS_LSB +: 2] = sens_sel;
        rd_val[CTRL_RAMP_LSB +: 2] = cfg.method;
        rd_val[CTRL_RISE_LSB +: 4] = cfg.rise_curve_shape;
        rd_val[CTRL_FALL_LSB +: 4] = cfg.fall_curve_shape;
      end
      OFS_SPEED_LIM:  rd_val[9:0] = speed_limit;
      OFS_RISE_TIME:  rd_val[9:0] = cfg.rise_time;
      OFS_FALL_SLOW:  rd_val[9:0] = cfg.fall_slow_time;
      OFS_FALL_FAST:  rd_val[9:0] = cfg.fall_fast_time;
      OFS_FAST_THR:   rd_val[9:0] = cfg.fast_fall_threshold;
      OFS_ABORT_THR:  rd_val[9:0] = cfg.fall_abort_threshold;
      OFS_ABORT_TIME: rd_val[9:0] = cfg.abort_time;
      OFS_STATUS: begin
        rd_val[GAIN_W-1:0] = active_gain;
        rd_val[STAT_FLOW_LSB +: FLOW_W] = spool_setpoint;
      end
      default: begin
        if (paddr >= OFS_GAIN0 && paddr <= OFS_GAIN_LAST &&
            paddr[1:0] == 2'h0)
          rd_val[GAIN_W-1:0] = gain_tab[3'(((paddr - OFS_GAIN0) >> 2))];
        else
          hit = 1'b0;
      end
    endcase
  end

  // Bus answer one cycle into the access phase, so read data is a flop
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
      prdata  <= '0;
    end else begin
      pready  <= acc && !pready;
      pslverr <= acc && !pready && !hit;
      if (acc && !pready && !pwrite)
        prdata <= rd_val;
    end
  end

  // Control and scalar settings; scalars and shapes clipped on write, selectors stored raw
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sens_sel    <= SENS_FIXED;
      speed_limit <= 10'(SPEED_LIM_RST);
      cfg.method  <= SGR_RAMP_OFF;                         // [RL9]
      cfg.rise_curve_shape     <= '0;                      // [RL13]
      cfg.fall_curve_shape     <= '0;
      cfg.rise_time            <= 10'(RISE_RST);           // [RL23]
      cfg.fall_slow_time       <= 10'(FALL_SLOW_RST);
      cfg.fall_fast_time       <= 10'(FALL_FAST_RST);
      cfg.fast_fall_threshold  <= 10'(FAST_THR_RST);
      cfg.fall_abort_threshold <= '0;
      cfg.abort_time           <= 10'(ABORT_TIME_RST);
    end else if (wr_en && hit) begin
      unique case (paddr)
        OFS_CTRL: begin
          sens_sel <= pwdata[CTRL_SENS_LSB +: 2];
          cfg.method <= sgr_ramp_t'(pwdata[CTRL_RAMP_LSB +: 2]);
          cfg.rise_curve_shape <= 4'(clip(
            DATA_W'(pwdata[CTRL_RISE_LSB +: 4]), 0, SHAPE_MAX));
          cfg.fall_curve_shape <= 4'(clip(
            DATA_W'(pwdata[CTRL_FALL_LSB +: 4]), 0, SHAPE_MAX));
        end
        OFS_SPEED_LIM:                                     // [RL6]
          speed_limit <= 10'(clip(pwdata, SPEED_LIM_MIN, SPEED_LIM_MAX));
        OFS_RISE_TIME:
          cfg.rise_time <= 10'(clip(pwdata, TIME_MIN, TIME_MAX));
        OFS_FALL_SLOW:
          cfg.fall_slow_time <= 10'(clip(pwdata, TIME_MIN, TIME_MAX));
        OFS_FALL_FAST:
          cfg.fall_fast_time <= 10'(clip(pwdata, TIME_MIN, TIME_MAX));
        OFS_FAST_THR:
          cfg.fast_fall_threshold <= 10'(clip(pwdata, 0, MAX_FLOW));
        OFS_ABORT_THR: begin
          // Value 1000 kept as the disable code, else 0..500
          if (pwdata[15:0] == 16'(ABORT_OFF))
            cfg.fall_abort_threshold <= 10'(ABORT_OFF);    // [RL20]
          else
            cfg.fall_abort_threshold <= 10'(clip(pwdata, 0,
                                                 ABORT_THR_MAX)); // [RL22]
        end
        OFS_ABORT_TIME:
          cfg.abort_time <= 10'(clip(pwdata, TIME_MIN, TIME_MAX));
        default: ;
      endcase
    end
  end

  // Gain table, one flop group per breakpoint
  genvar gi;
  generate
    for (gi = 0; gi < NUM_GAINS; gi++) begin : g_gain
      always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn)                                        // [RL7]
          gain_tab[gi] <= GAIN_W'(GAIN_RST0 - gi * GAIN_RST_STEP);
        else if (wr_en && paddr == OFS_GAIN0 + ADDR_W'(gi * 4))
          gain_tab[gi] <= clip(pwdata, GAIN_MIN, GAIN_MAX);
      end
    end
  endgenerate

  // Speed gain schedule; assumes gains do not rise with speed
  always_comb begin
    int s;
    int lo;
    int hi;
    int idx;
    int g;
    s   = int'(vehicle_speed_value);
    lo  = 0;
    hi  = 0;
    idx = 0;
    g   = int'(gain_tab[0]);
    if (s < 0) s = -s;                                       // [RL3]
    if (sens_sel == SENS_SPEED) begin                        // [RL1]
      if (s >= int'(speed_limit)) begin
        g = int'(gain_tab[NUM_GAINS-1]);                     // [RL24]
      end else if (s != 0) begin
        // Standstill always keeps gain 0, even when small limits collapse
        // the low segments onto zero width
        // Breakpoint k sits at limit >> (5-k)
        for (int k = 1; k < NUM_GAINS; k++) begin            // [RL5]
          if (idx == 0 && s < (int'(speed_limit) >> (NUM_GAINS - 1 - k))) begin
            idx = k;
            hi  = int'(speed_limit) >> (NUM_GAINS - 1 - k);
            lo  = (k == 1) ? 0 : (int'(speed_limit) >> (NUM_GAINS - k));
          end
        end
        // Zero speed lands on the standstill gain exactly
        if (idx != 0 && hi > lo)                             // [RL2] [RL4]
          g = int'(gain_tab[idx-1]) -
              (int'(gain_tab[idx-1]) - int'(gain_tab[idx])) * (s - lo) /
              (hi - lo);
        else if (idx != 0)
          g = int'(gain_tab[idx]);
      end
    end
    next_gain = GAIN_W'(g);
  end

  // Request scaling by gain, limited to full flow
  always_comb begin
    int f;
    f = int'(steer_input) * int'(active_gain) / GAIN_UNITY;
    if (f > MAX_FLOW) f = MAX_FLOW;
    if (f < -MAX_FLOW) f = -MAX_FLOW;
    next_flow = FLOW_W'(f);
  end

  // Fixed 1 ms tick; speed-dependent method runs on fixed times
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tick_cnt <= '0;
      tick     <= 1'b0;
    end else begin
      tick     <= (tick_cnt == 32'(TICK_DIV - 1));         // [RL25]
      tick_cnt <= (tick_cnt == 32'(TICK_DIV - 1)) ? '0 : tick_cnt + 32'h1;
    end
  end

  // Ramp step toward the request, magnitude plus direction
  always_comb begin
    int sp;
    int rq;
    int tgt;
    int step;
    int mag;
    int full;
    logic rq_neg;
    logic opposite;
    full     = MAX_FLOW << FRAC_W;
    sp       = int'(sp_mag);
    rq_neg   = requested_flow < 0;
    rq       = (rq_neg ? -int'(requested_flow) : int'(requested_flow))
               << FRAC_W;
    mag      = sp >> FRAC_W;
    opposite = (sp != 0) && (rq_neg != sp_neg);
    next_sp_neg  = sp_neg;
    next_aborted = aborted;
    step     = 0;
    tgt      = 0;
    if (!opposite && rq >= sp) begin
      // Rise; shape adds speed as flow grows
      step = full / int'(cfg.rise_time);                     // [RL11]
      step = step + step * int'(cfg.rise_curve_shape) * mag / SHAPE_DIV;
      tgt  = (sp + step > rq) ? rq : sp + step;
      next_aborted = 1'b0;
      if (sp == 0)
        next_sp_neg = rq_neg;
    end else begin
      tgt = opposite ? 0 : rq;
      if (mag > int'(cfg.fast_fall_threshold)) begin         // [RL14] [RL15]
        // Full-scale time, so the range takes width/1000 of it
        step = full / int'(cfg.fall_fast_time);              // [RL16]
      end else begin
        if (opposite && int'(cfg.fall_abort_threshold) != ABORT_OFF &&
            (rq >> FRAC_W) > int'(cfg.fall_abort_threshold))
          next_aborted = 1'b1;                               // [RL18] [RL20]
        if (next_aborted)
          step = full / int'(cfg.abort_time);                // [RL19]
        else begin
          step = full / int'(cfg.fall_slow_time);            // [RL12]
          step = step + step * int'(cfg.fall_curve_shape) *
                 (MAX_FLOW - mag) / SHAPE_DIV;               // [RL13]
        end
      end
      tgt = (sp - step < tgt) ? tgt : sp - step;
      if (tgt == 0)
        next_aborted = 1'b0;
    end
    next_sp_mag = (FLOW_W + FRAC_W)'(tgt);
  end

  // Set-point state; ramps off passes the request straight through
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sp_mag  <= '0;
      sp_neg  <= 1'b0;
      aborted <= 1'b0;
    end else if (cfg.method == SGR_RAMP_OFF) begin
      sp_mag  <= (FLOW_W + FRAC_W)'(
        (requested_flow < 0 ? -int'(requested_flow) : int'(requested_flow))
        << FRAC_W);
      sp_neg  <= requested_flow < 0;
      aborted <= 1'b0;
    end else if (tick) begin                                  // [RL10]
      sp_mag  <= next_sp_mag;
      sp_neg  <= next_sp_neg;
      aborted <= next_aborted;
    end
  end

  // Registered outputs
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      active_gain    <= GAIN_W'(GAIN_RST0);
      requested_flow <= '0;
      spool_setpoint <= '0;
    end else begin
      active_gain    <= next_gain;
      requested_flow <= next_flow;
      spool_setpoint <= sp_neg ? -FLOW_W'(sp_mag >> FRAC_W)
                               : FLOW_W'(sp_mag >> FRAC_W);
    end
  end

endmodule

// [tb/sgr_checker.sv]
`timescale 1ns/1ps
module sgr_checker
  import sgr_pkg::*;
(
  // Clock and reset
  input wire logic                     pclk,
  input wire logic                     presetn,
  // APB
  input wire logic                     psel,
  input wire logic                     penable,
  input wire logic                     pwrite,
  input wire logic [ADDR_W-1:0]        paddr,
  input wire logic [DATA_W-1:0]        pwdata,
  input wire logic [DATA_W-1:0]        prdata,
  input wire logic                     pready,
  input wire logic                     pslverr,
  // Flow path
  input wire logic signed [FLOW_W-1:0] steer_input,
  input wire logic signed [SPEED_W:0]  vehicle_speed_value,
  input wire logic signed [FLOW_W-1:0] spool_setpoint,
  input wire logic signed [FLOW_W-1:0] requested_flow,
  input wire logic [GAIN_W-1:0]        active_gain
);
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  // Access phase still waiting for its answer
  sequence s_wait;
    psel && penable && !pready;
  endsequence
  // Request quiet around a moment where the spool has caught up
  sequence s_settled;
    $stable(requested_flow) [*3] ##0 (spool_setpoint == requested_flow)
    ##1 $stable(requested_flow) [*3];
  endsequence

  pready_pulse_a: assert property (pready |=> !pready)
    else $error("pready held longer than one cycle");
  one_wait_a: assert property (s_wait |=> pready)
    else $error("pready not after exactly one wait state");
  err_ready_a: assert property (pslverr |-> pready)
    else $error("pslverr without pready");
  err_zero_a: assert property (pslverr && !pwrite |-> prdata == '0)
    else $error("refused read returned data");
  mapped_ok_a: assert property (
    pready && paddr <= OFS_STATUS && paddr[1:0] == 2'h0 |-> !pslverr)
    else $error("mapped register refused");
  status_mirror_a: assert property (
    pready && !pwrite && paddr == OFS_STATUS && $stable(spool_setpoint)
    |-> prdata[26:16] == spool_setpoint)
    else $error("status does not mirror the set-point");
  gain_range_a: assert property (
    active_gain >= GAIN_MIN && active_gain <= GAIN_MAX)
    else $error("gain out of range");
  flow_clamp_a: assert property (
    requested_flow >= -MAX_FLOW && requested_flow <= MAX_FLOW
    && spool_setpoint >= -MAX_FLOW && spool_setpoint <= MAX_FLOW)
    else $error("flow beyond full scale");
  spool_hold_a: assert property (
    s_settled |-> spool_setpoint == requested_flow)
    else $error("set-point left a reached request");
endmodule

bind sgr_top sgr_checker chk_u (
  .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
  .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
  .pready(pready), .pslverr(pslverr), .steer_input(steer_input),
  .vehicle_speed_value(vehicle_speed_value),
  .spool_setpoint(spool_setpoint), .requested_flow(requested_flow),
  .active_gain(active_gain)
);

// [tb/sgr_steer_model.sv]
`timescale 1ns/1ps
module sgr_steer_model
  import sgr_pkg::*;
(
  // Clock and reset
  input  wire logic                     pclk,
  input  wire logic                     presetn,
  // Bench commands
  input  wire logic                     slow,
  input  wire logic signed [FLOW_W-1:0] steer_cmd,
  input  wire logic signed [SPEED_W:0]  speed_cmd,
  // Device side
  output logic signed [FLOW_W-1:0]      steer_input,
  output logic signed [SPEED_W:0]       vehicle_speed_value
);
  logic [1:0] div;

  // Slow sensors refresh every fourth cycle only, so values arrive late
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      div                 <= 2'h0;
      steer_input         <= '0;
      vehicle_speed_value <= '0;
    end else begin
      div <= div + 2'h1;
      if (!slow || div == 2'h0) begin
        steer_input         <= steer_cmd;
        vehicle_speed_value <= speed_cmd;
      end
    end
  end
endmodule

// [tb/tb_top.sv]
`timescale 1ns/1ps
module tb_top;
  import sgr_pkg::*;
  localparam int TD  = 20;
  localparam int LIM = 800;
  logic                     pclk = 1'b0;
  logic                     presetn, psel, penable, pwrite, slow, e;
  logic [ADDR_W-1:0]        paddr, a;
  logic [DATA_W-1:0]        pwdata, prdata, q;
  logic                     pready, pslverr;
  logic signed [FLOW_W-1:0] steer_input, spool_setpoint, requested_flow;
  logic signed [FLOW_W-1:0] steer_cmd;
  logic signed [SPEED_W:0]  vehicle_speed_value, speed_cmd;
  logic [GAIN_W-1:0]        active_gain;
  int                       miscompares = 0;
  int                       comparisons = 0;
  int                       cycles = 0;
  int                       sp, st, g;
  int cs[6] = '{0, LIM >> 4, (LIM >> 3) - 1, LIM - 1, LIM, -(LIM >> 2) - 7};
  int cw[4] = '{5, 5000, 0, 2000};
  int cx[4] = '{GAIN_MIN, GAIN_MAX, SPEED_LIM_MIN, SPEED_LIM_MAX};

  sgr_top #(.TICK_DIV(TD)) dut_u (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .steer_input(steer_input),
    .vehicle_speed_value(vehicle_speed_value),
    .spool_setpoint(spool_setpoint), .requested_flow(requested_flow),
    .active_gain(active_gain));
  sgr_steer_model mdl_u (
    .pclk(pclk), .presetn(presetn), .slow(slow), .steer_cmd(steer_cmd),
    .speed_cmd(speed_cmd), .steer_input(steer_input),
    .vehicle_speed_value(vehicle_speed_value));

  // Clock and hang guard
  always #10 pclk = ~pclk;
  always @(posedge pclk) begin
    cycles <= cycles + 1;
    if (cycles == 30000) begin
      miscompares++;
      stop_test;
    end
  end

  task automatic stop_test;
    $display("comparisons %0d mismatches %0d", comparisons, miscompares);
    if (miscompares == 0 && comparisons > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask

  task automatic tk(input int n);
    repeat (n) @(posedge pclk);
    #1;
  endtask

  task automatic chk(input string n, input logic [31:0] s,
                     input logic [31:0] x);
    comparisons++;
    if (s !== x) begin
      miscompares++;
      $display("[ERR] %s expected %h seen %h", n, x, s);
    end
  endtask

  // APB transfer; request held until pready is sampled high
  task automatic apb(input logic w, input logic [ADDR_W-1:0] ad,
                     input logic [31:0] d);
    int n;
    @(posedge pclk);
    psel   <= 1'b1;
    pwrite <= w;
    paddr  <= ad;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 50);
    if (pready !== 1'b1)
      miscompares++;
    q = prdata;
    e = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic drive(input int s, input int v);
    @(posedge pclk);
    steer_cmd <= FLOW_W'(s);
    speed_cmd <= (SPEED_W + 1)'(v);
  endtask

  // One tick after the first move, the set-point moved by one step
  task automatic step(input int s, input int x);
    logic signed [31:0] v0;
    v0 = spool_setpoint;
    drive(s, 0);
    for (int n = 0; n < 4 * TD && spool_setpoint === v0; n++)
      tk(1);
    v0 = spool_setpoint;
    tk(TD);
    chk("ramp step", spool_setpoint - v0, 32'(x));
    tk(25 * TD);
  endtask

  function automatic int rv(int i);
    case (i)
      0: return 1;
      1: return SPEED_LIM_RST;
      2, 3, 4, 5, 6, 7: return GAIN_RST0 - GAIN_RST_STEP * (i - 2);
      8: return RISE_RST;
      9: return FALL_SLOW_RST;
      10: return FALL_FAST_RST;
      11: return FAST_THR_RST;
      13: return ABORT_TIME_RST;
      14: return GAIN_RST0;
      default: return 0;
    endcase
  endfunction

  function automatic int ef(int s, int gn);
    int f;
    f = s * gn / GAIN_UNITY;
    return f > MAX_FLOW ? MAX_FLOW : (f < -MAX_FLOW ? -MAX_FLOW : f);
  endfunction

  // Gain from speed magnitude, interpolated between breakpoints
  function automatic int eg(int v);
    int gt[6] = '{105, 90, 75, 60, 45, 30};
    int b[6] = '{0, LIM >> 4, LIM >> 3, LIM >> 2, LIM >> 1, LIM};
    if (v < 0)
      v = -v;
    for (int i = 0; i < 5; i++)
      if (v < b[i+1])
        return gt[i] + (gt[i+1] - gt[i]) * (v - b[i]) / (b[i+1] - b[i]);
    return gt[5];
  endfunction

  initial begin
    presetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = '0;
    pwdata = '0;
    steer_cmd = '0;
    speed_cmd = '0;
    slow = 1'b0;
    void'($urandom(32'hcaf2));
    repeat (5) @(posedge pclk);
    presetn <= 1'b1;
    tk(2);
    // Reset values of every word, then one unmapped word
    for (int i = 0; i < 16; i++) begin
      apb(1'b0, ADDR_W'(4 * i), '0);
      chk("reset value", q, 32'(rv(i)));
      chk("slave error", 32'(e), 32'(i == 15));
    end
    // Out-of-range writes are clipped
    for (int i = 0; i < 4; i++) begin
      a = i < 2 ? OFS_GAIN0 : OFS_SPEED_LIM;
      apb(1'b1, a, 32'(cw[i]));
      apb(1'b0, a, '0);
      chk("clipped value", q, 32'(cx[i]));
    end
    apb(1'b1, OFS_GAIN0, 32'(GAIN_RST0));
    apb(1'b1, OFS_SPEED_LIM, 32'(LIM));
    apb(1'b1, OFS_CTRL, 32'h3);
    $display("test registers done");
    // Gain schedule, corners then random, slow sensors
    slow = 1'b1;
    for (int i = 0; i < 24; i++) begin
      if (i == 18)
        apb(1'b1, OFS_CTRL, 32'h1);
      sp = i < 6 ? cs[i] : int'($urandom_range(2200)) - 1100;
      st = int'($urandom_range(2000)) - 1000;
      drive(st, sp);
      tk(12);
      g = i < 18 ? eg(sp) : GAIN_RST0;
      chk("gain", active_gain, 32'(g));
      chk("flow", requested_flow, 32'(ef(st, g)));
      chk("spool", spool_setpoint, 32'(ef(st, g)));
    end
    slow = 1'b0;
    $display("test gain done");
    // Fixed then speed-dependent ramps; fast and abort times below the slow time
    apb(1'b1, OFS_CTRL, 32'h11);
    apb(1'b1, OFS_RISE_TIME, 32'd10);
    apb(1'b1, OFS_FALL_SLOW, 32'd20);
    apb(1'b1, OFS_FALL_FAST, 32'd5);
    apb(1'b1, OFS_ABORT_TIME, 32'd4);
    apb(1'b1, OFS_ABORT_THR, 32'(ABORT_OFF));
    drive(0, 0);
    tk(25 * TD);
    step(1000, 100);
    step(0, -50);
    step(1000, 100);
    apb(1'b1, OFS_FAST_THR, 32'd600);
    step(0, -200);
    apb(1'b1, OFS_FAST_THR, 32'(FAST_THR_RST));
    apb(1'b1, OFS_CTRL, 32'h21);
    step(1000, 100);
    apb(1'b1, OFS_ABORT_THR, 32'd100);
    step(-476, -250);
    apb(1'b1, OFS_ABORT_THR, 32'(ABORT_OFF));
    step(1000, 50);
    $display("test ramp done");
    stop_test;
  end
endmodule
